// *** hdl/swgc_pkg.sv ***
// Constants shared by the global switch control register block
package swgc_pkg;
  // ==========================================================
  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_GCTL1 = 8'h02;
  // ==========================================================
  // Identity register fields
  localparam int ID_FAMILY_LSB = 8;
  localparam int ID_CHIP_LSB = 4;
  localparam int ID_REV_LSB = 1;
  localparam int ID_START_BIT = 0;
  localparam logic ID_START_RST = 1'b0;
  // ==========================================================
  // Global control one fields
  localparam int G1_PASS_ALL = 15;
  localparam int G1_TX_PAUSE = 13;
  localparam int G1_RX_PAUSE = 12;
  localparam int G1_LEN_CHK = 11;
  localparam int G1_AGE_EN = 10;
  localparam int G1_FAST_AGE = 9;
  localparam int G1_AGGR_BO = 8;
  localparam int G1_PASS_FC = 3;
  localparam int G1_LINK_AGE = 0;
  localparam logic [15:0] G1_RST = 16'h3400;
  // ==========================================================
  // Frame length check
  localparam logic [15:0] LEN_TYPE_LIMIT = 16'h05DC; // 1500
  // ==========================================================
  // Aging times and their cycle counts
  localparam longint unsigned CLK_HZ = 25000000;
  localparam longint unsigned NORM_AGE_S = 300;
  localparam longint unsigned FAST_AGE_US = 800;
  localparam longint unsigned NORM_AGE_CYC = NORM_AGE_S * CLK_HZ;
  localparam longint unsigned FAST_AGE_CYC = (FAST_AGE_US * CLK_HZ) / 1000000;
  // Link-change cycle must be strictly shorter than the fast one
  localparam longint unsigned LINK_AGE_CYC = FAST_AGE_CYC - 1;
  localparam int AGE_CNT_W = 36;
endpackage : swgc_pkg

// *** hdl/age_ctrl_if.sv ***
// Carrier between control registers, aging timer and link monitor
`timescale 1ns/100ps
interface age_ctrl_if;
  logic age_en; // Aging runs
  logic fast; // Fast period selected
  logic lc_req; // Link-change one-shot request, pulse
  logic tick; // Age cycle completed, pulse
  logic loss; // Some port lost link, pulse
  modport ctrl (output age_en, output fast, output lc_req, input tick, input loss);
  modport ager (input age_en, input fast, input lc_req, output tick);
  modport mon (output loss);
endinterface : age_ctrl_if

// *** hdl/age_timer.sv ***
// Aging period timer with normal, fast and link-change periods
`timescale 1ns/100ps
module age_timer #(
  parameter logic [35:0] NORM_CYC = 36'(swgc_pkg::NORM_AGE_CYC),
  parameter logic [35:0] FAST_CYC = 36'(swgc_pkg::FAST_AGE_CYC),
  parameter logic [35:0] LINK_CYC = 36'(swgc_pkg::LINK_AGE_CYC)
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  age_ctrl_if.ager bus
);
  // ==========================================================
  // Counter state
  logic [35:0] cnt_r; // Cycles into current period
  logic os_r; // One short link-change cycle pending after link change
  wire [35:0] period = os_r ? LINK_CYC : (bus.fast ? FAST_CYC : NORM_CYC);
  // At or past the last count: a switch to a shorter period after the
  // count has passed it expires at once instead of wrapping the counter
  wire expire = bus.age_en && (cnt_r >= period - 36'h1);
  logic tick_r;
  assign bus.tick = tick_r;

  // Count only while aging is on; a request restarts the period [R7] [R11]
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_r <= 36'h0;
      os_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= expire; // [R7]
      if (bus.lc_req) begin
        cnt_r <= 36'h0; // Short link-change cycle measured from the link drop [R11]
      end else if (!bus.age_en || expire) begin
        cnt_r <= 36'h0;
      end else begin
        cnt_r <= cnt_r + 36'd1;
      end
      // Set wins over the clear at end of cycle [R11]
      if (bus.lc_req) begin
        os_r <= 1'b1;
      end else if (expire) begin
        os_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  chk_age_halted: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R7]
    !bus.age_en |=> !bus.tick) else $error("aging ticked while disabled");
  chk_fast_expiry: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R8]
    bus.age_en && bus.fast && !os_r && !bus.lc_req && cnt_r == FAST_CYC - 36'd1
    |=> bus.tick) else $error("fast age period not honoured");
  chk_oneshot_ends: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R11]
    expire && !bus.lc_req |=> !os_r) else $error("link-change cycle did not end");
  cov_oneshot: cover property (@(posedge i_clk) disable iff (!i_rst_b) os_r && expire);
endmodule : age_timer

// *** hdl/link_loss_detect.sv ***
// Detects any port dropping from link to no link
`timescale 1ns/100ps
module link_loss_detect #(
  parameter int N_PORTS = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [N_PORTS-1:0] i_link,
  age_ctrl_if.mon bus
);
  // ==========================================================
  // Per-port edge detect
  logic [N_PORTS-1:0] prev_r; // Link level last cycle
  logic [N_PORTS-1:0] fall; // Link lost this cycle
  logic loss_r;
  assign bus.loss = loss_r;

  genvar g;
  generate
    for (g = 0; g < N_PORTS; g++) begin : g_port
      assign fall[g] = prev_r[g] && !i_link[g];
    end
  endgenerate

  // Reset level zero, so a link down at start is not a loss
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prev_r <= '0;
      loss_r <= 1'b0;
    end else begin
      prev_r <= i_link;
      loss_r <= |fall; // [R12]
    end
  end

  chk_loss_seen: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R12]
    |fall |=> bus.loss) else $error("link loss missed");
  cov_loss: cover property (@(posedge i_clk) disable iff (!i_rst_b) bus.loss);
endmodule : link_loss_detect

// *** hdl/switch_global_control_regs.sv ***
// Switch identity and global control registers with aging control
`timescale 1ns/100ps
// Operation
// [R1] Fabric off until start bit written one
// [R2] Identity fields read-only: family, chip, revision
// [R3] Pass all frames only with sniffer mode
// [R4] Transmit pause enable gates pause frame generation
// [R5] Receive pause enable gates reaction to pause
// [R6] Length check drops mismatched IEEE frames
// [R7] Aging runs only while enable set
// [R8] Fast age bit selects 800us period
// [R9] Bit 8 selects aggressive half-duplex back-off
// [R10] Bit 3 forwards flow control frames
// [R11] Link drop triggers one short age cycle
// [R12] Any cable loss ages out all addresses
// [R13] Reserved bits store writes, no effect
module switch_global_control_regs #(
  parameter logic [35:0] NORM_AGE_CYC = 36'(swgc_pkg::NORM_AGE_CYC),
  parameter logic [35:0] FAST_AGE_CYC = 36'(swgc_pkg::FAST_AGE_CYC),
  parameter logic [35:0] LINK_AGE_CYC = 36'(swgc_pkg::LINK_AGE_CYC),
  parameter int N_PORTS = 2,
  // Identity values, arbitrary
  parameter logic [7:0] FAMILY_CODE = 8'h5A,
  parameter logic [3:0] CHIP_CODE = 4'h3,
  parameter logic [2:0] REV_CODE = 3'h2
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [swgc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [swgc_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [swgc_pkg::DATA_W-1:0] o_rd_data,
  // Switch status inputs
  input wire logic [N_PORTS-1:0] i_link,
  input wire logic i_sniff_mode,
  // Frame length check request
  input wire logic i_len_valid,
  input wire logic [15:0] i_len_field,
  input wire logic [15:0] i_frame_len,
  // Controls to the fabric and MACs
  output logic o_switch_en,
  output logic o_pass_all_frames,
  output logic o_tx_pause_en,
  output logic o_rx_pause_en,
  output logic o_len_drop,
  output logic o_aggr_backoff,
  output logic o_pass_fc_frames,
  output logic o_age_tick,
  output logic o_flush_all
);
  // ==========================================================
  // Parameter checks
  // One-shot period must be the shortest,
  // normal the longest, or the select
  // below picks nonsense.
  // A zero link period would wrap and run the full counter range.
  // The loss detector needs one port at least.
  generate
    if (!(LINK_AGE_CYC > 36'd0 && LINK_AGE_CYC < FAST_AGE_CYC &&
          FAST_AGE_CYC < NORM_AGE_CYC) || N_PORTS < 1) begin : g_bad
      $error("aging periods must satisfy 0 < link < fast < normal");
    end
  endgenerate

  // ==========================================================
  // Register storage
  // Synchronous reset clears all of it but control one, which loads 16'h3400.
  // Read data have a register of their own
  // so the answer stands a cycle late.
  logic start_r; // Start control bit
  logic [15:0] gctl1_r; // Global control one, reserved bits kept too
  logic [15:0] rd_r; // Read data holding register
  logic pass_all_r; // Pass-all qualified by sniffer mode
  logic len_drop_r; // Drop decision for the frame offered
  logic tick_r; // Registered age tick
  logic flush_r; // Registered flush request

  // ==========================================================
  // Address decode
  // Full byte offsets compared: odd offsets
  // and gaps between registers select nothing.
  // Unmapped writes vanish without side effect.
  // Write then read back to back is allowed;
  // the read sees the word just stored.
  wire sel_ident = (i_addr == swgc_pkg::OFS_IDENT);
  wire sel_gctl1 = (i_addr == swgc_pkg::OFS_GCTL1);
  wire wr_ident = i_wr && sel_ident;
  wire wr_gctl1 = i_wr && sel_gctl1;

  // Family, chip and revision come from
  // parameters and have no storage, so no
  // write can ever reach them.
  // Identity word: read-only fields plus the live start bit [R2]
  wire [15:0] ident_word = {FAMILY_CODE, CHIP_CODE, REV_CODE, start_r};

  // Captured on the strobe, held until the
  // next one: a slow reader needs no repeat.
  // Both registers share this read path.
  // Unmapped reads return zero
  wire [15:0] rd_nxt = !i_rd ? rd_r :
                       sel_ident ? ident_word :
                       sel_gctl1 ? gctl1_r : 16'h0000;

  // Clearing the bit stops the fabric at
  // once; there is no drain phase here.
  // Other bits of the write word are ignored.
  // Only the start bit of the identity word is writable [R1] [R2]
  wire start_nxt = wr_ident ? i_wr_data[swgc_pkg::ID_START_BIT] : start_r;

  // Reserved bits read back and drive
  // nothing, so read-modify-write is safe.
  // Reset value holds until the first write.
  // Whole word is stored, reserved bits included [R13]
  wire [15:0] gctl1_nxt = wr_gctl1 ? i_wr_data : gctl1_r;

  // ==========================================================
  // Field decode
  // Bits that steer the aging timer; pause,
  // back-off and pass bits go to outputs.
  // Plain wires, no added latency.
  wire age_en = gctl1_r[swgc_pkg::G1_AGE_EN];
  wire fast_age = gctl1_r[swgc_pkg::G1_FAST_AGE];
  wire link_age = gctl1_r[swgc_pkg::G1_LINK_AGE];

  // Outside sniffer mode the bit is kept but
  // idle, so bad frames never leak out.
  // Pass-all only counts in sniffer mode; meant for debug only [R3]
  wire pass_all_nxt = gctl1_r[swgc_pkg::G1_PASS_ALL] && i_sniff_mode;

  // Values at or above the limit are type
  // codes, not lengths, never compared.
  // One decision per offer, a cycle later.
  // Length field compared only for IEEE frames below the limit [R6]
  wire is_ieee = (i_len_field < swgc_pkg::LEN_TYPE_LIMIT);
  wire len_mismatch = (i_len_field != i_frame_len);
  wire len_drop_nxt = i_len_valid && gctl1_r[swgc_pkg::G1_LEN_CHK] &&
                      is_ieee && len_mismatch;

  // ==========================================================
  // Aging datapath
  // Timer and loss detector share a carrier.
  // A link-change request restarts the timer
  // for one short period, then it falls back
  // to the fast or normal period.
  // Flush on loss ignores the link-change bit.
  // Limitation: normal period is one exact
  // count; no spread around it is modelled.
  // Trade-off: one wide counter for all three
  // periods, wider than fast alone needs.
  age_ctrl_if age_bus ();
  assign age_bus.age_en = age_en; // [R7]
  assign age_bus.fast = fast_age; // [R8]
  // Link-change aging only when enabled; flush happens regardless
  assign age_bus.lc_req = age_bus.loss && link_age; // [R11]

  // Period timer: normal, fast, one-shot
  age_timer #(
    .NORM_CYC(NORM_AGE_CYC),
    .FAST_CYC(FAST_AGE_CYC),
    .LINK_CYC(LINK_AGE_CYC)
  ) u_age_timer (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .bus(age_bus)
  );

  // Loss detector: any port losing link
  link_loss_detect #(
    .N_PORTS(N_PORTS)
  ) u_link_loss (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_link(i_link),
    .bus(age_bus)
  );

  // ==========================================================
  // Register update
  // Software-visible state: start bit,
  // control one and read data. Reset turns
  // pause handling and aging on, rest off.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      start_r <= swgc_pkg::ID_START_RST; // Fabric held off [R1]
      gctl1_r <= swgc_pkg::G1_RST; // [R4] [R5] [R7]
      rd_r <= 16'h0000;
    end else begin
      start_r <= start_nxt; // [R1]
      gctl1_r <= gctl1_nxt; // [R13]
      rd_r <= rd_nxt;
    end
  end

  // Registering costs one cycle of latency
  // but keeps every output on a flop.
  // Qualified controls and event outputs, each from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pass_all_r <= 1'b0;
      len_drop_r <= 1'b0;
      tick_r <= 1'b0;
      flush_r <= 1'b0;
    end else begin
      pass_all_r <= pass_all_nxt; // [R3]
      len_drop_r <= len_drop_nxt; // [R6]
      tick_r <= age_bus.tick;
      flush_r <= age_bus.loss; // Age out everything on cable loss [R12]
    end
  end

  // ==========================================================
  // Outputs
  // Levels follow the register bits; tick,
  // flush and drop are one-cycle pulses.
  assign o_rd_data = rd_r;
  assign o_switch_en = start_r; // [R1]
  assign o_pass_all_frames = pass_all_r;
  assign o_tx_pause_en = gctl1_r[swgc_pkg::G1_TX_PAUSE]; // [R4]
  assign o_rx_pause_en = gctl1_r[swgc_pkg::G1_RX_PAUSE]; // [R5]
  assign o_len_drop = len_drop_r;
  assign o_aggr_backoff = gctl1_r[swgc_pkg::G1_AGGR_BO]; // [R9]
  assign o_pass_fc_frames = gctl1_r[swgc_pkg::G1_PASS_FC]; // [R10]
  assign o_age_tick = tick_r;
  assign o_flush_all = flush_r;

  // ==========================================================
  // Checks
  // Bus checks look one cycle after the
  // strobe, where the result stands; pulses
  // are checked in the cycle they stand.
  chk_start_enables: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R1]
    wr_ident |=> o_switch_en == $past(i_wr_data[0])) else $error("start bit not applied");
  chk_ident_fixed: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R2]
    i_rd && sel_ident |=> o_rd_data[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE})
    else $error("identity fields changed");
  chk_pass_all_sniff: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R3]
    !i_sniff_mode |=> !o_pass_all_frames) else $error("pass-all without sniffer");
  chk_tx_pause_off: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R4]
    wr_gctl1 && !i_wr_data[13] |=> !o_tx_pause_en) else $error("tx pause not off");
  chk_rx_pause_off: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R5]
    wr_gctl1 && !i_wr_data[12] |=> !o_rx_pause_en) else $error("rx pause not off");
  chk_len_drop_req: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R6]
    i_len_valid && gctl1_r[11] && i_len_field < 16'h05DC && i_len_field != i_frame_len
    |=> o_len_drop) else $error("mismatched frame not dropped");
  chk_len_keep_eth: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R6]
    i_len_field >= 16'h05DC |=> !o_len_drop) else $error("ethernet frame dropped");
  chk_backoff_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R9]
    wr_gctl1 |=> o_aggr_backoff == $past(i_wr_data[8])) else $error("back-off not set");
  chk_pass_fc_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R10]
    wr_gctl1 |=> o_pass_fc_frames == $past(i_wr_data[3])) else $error("fc pass not set");
  chk_flush_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R12]
    age_bus.loss |=> o_flush_all) else $error("flush not raised");
  chk_reserved_kept: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R13]
    wr_gctl1 ##1 (i_rd && sel_gctl1 && !i_wr) |=> o_rd_data == $past(i_wr_data, 2))
    else $error("control word not read back");
  // Start moves only on an identity write
  chk_start_held: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R1]
    !wr_ident |=> $stable(o_switch_en)) else $error("start moved without write");

  // Control word moves only on its write
  chk_ctl_held: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R13]
    !wr_gctl1 |=> $stable(gctl1_r)) else $error("control moved without write");

  // Pass-all applies once sniffer mode is on
  chk_pass_all_on: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R3]
    gctl1_r[swgc_pkg::G1_PASS_ALL] && i_sniff_mode |=> o_pass_all_frames)
    else $error("pass-all not applied");

  // Pause directions come back when set
  chk_tx_pause_on: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R4]
    wr_gctl1 && i_wr_data[swgc_pkg::G1_TX_PAUSE] |=> o_tx_pause_en)
    else $error("tx pause not on");
  chk_rx_pause_on: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R5]
    wr_gctl1 && i_wr_data[swgc_pkg::G1_RX_PAUSE] |=> o_rx_pause_en)
    else $error("rx pause not on");

  // No drop while length checking is off
  chk_len_check_off: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R6]
    !gctl1_r[swgc_pkg::G1_LEN_CHK] |=> !o_len_drop) else $error("drop while check off");

  // No tick two cycles after aging is off
  chk_tick_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R7]
    !age_en |-> ##2 !o_age_tick) else $error("age tick while aging off");

  // Read data stand until the next strobe
  chk_read_holds: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_rd |=> $stable(o_rd_data)) else $error("read data changed without read");

  // Places outside both registers read zero
  chk_unmapped_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_rd && !sel_ident && !sel_gctl1 |=> o_rd_data == 16'h0000)
    else $error("unmapped place not zero");

  // Covers for the main scenarios
  cov_start: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_switch_en));
  cov_len_drop: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_len_drop);
  cov_back_to_back: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_gctl1 ##1 (i_rd && sel_gctl1));
endmodule : switch_global_control_regs

// *** testbench/tb_switch_global_control_regs.sv ***
// Self-checking bench for the global switch control registers
`timescale 1ns/100ps
module tb_switch_global_control_regs;
  // ==========================================================
  // Shortened aging periods keep the run brief
  localparam int NORM = 200;
  localparam int FAST = 50;
  localparam int LINK = 20;
  // Identity values, arbitrary
  localparam logic [14:0] ID_V = {8'h6C, 4'h9, 3'h5};
  localparam logic [15:0] CORNER [4] = '{16'h05DB, 16'h05DC, 16'h0000, 16'hFFFF};
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0; // Held low at start
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wr_data = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] i_link = 2'h3; // Both ports linked
  logic i_sniff_mode = 1'b0;
  logic i_len_valid = 1'b0;
  logic [15:0] i_len_field = 16'h0000;
  logic [15:0] i_frame_len = 16'h0000;
  logic [15:0] o_rd_data;
  logic o_switch_en, o_pass_all_frames, o_tx_pause_en, o_rx_pause_en;
  logic o_len_drop, o_aggr_backoff, o_pass_fc_frames, o_age_tick, o_flush_all;
  int fail_count = 0;
  int samples_checked = 0;
  logic [15:0] rnd = 16'h0036; // Random state, fixed seed
  logic [15:0] ctl_m = 16'h3400; // Mirror of control one
  logic [15:0] f;
  logic [15:0] l;
  int n;
  int n2;
  // ==========================================================
  // Design under test
  switch_global_control_regs #(.NORM_AGE_CYC(36'(NORM)), .FAST_AGE_CYC(36'(FAST)),
    .LINK_AGE_CYC(36'(LINK)), .N_PORTS(2), .FAMILY_CODE(8'h6C), .CHIP_CODE(4'h9),
    .REV_CODE(3'h5)) switch_global_control_regs_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .i_link(i_link), .i_sniff_mode(i_sniff_mode),
    .i_len_valid(i_len_valid), .i_len_field(i_len_field), .i_frame_len(i_frame_len),
    .o_switch_en(o_switch_en), .o_pass_all_frames(o_pass_all_frames),
    .o_tx_pause_en(o_tx_pause_en), .o_rx_pause_en(o_rx_pause_en),
    .o_len_drop(o_len_drop), .o_aggr_backoff(o_aggr_backoff),
    .o_pass_fc_frames(o_pass_fc_frames), .o_age_tick(o_age_tick),
    .o_flush_all(o_flush_all));
  // ==========================================================
  // Expectation helpers
  // Sixteen-bit feedback shift register
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // Drop only mismatching IEEE-format frames while checking is on
  function automatic logic exp_drop(input logic [15:0] c, input logic [15:0] fl,
                                    input logic [15:0] ln);
    return c[11] && (fl < 16'h05DC) && (fl != ln);
  endfunction : exp_drop
  // Compare and count
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Verdict, the single end of the run
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // ==========================================================
  // Bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(name, exp, o_rd_data);
  endtask : rd
  // Write then read the same place with no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input string name);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(name, d, o_rd_data);
  endtask : wr_rd
  // Offer one frame to the length checker
  task automatic len_chk(input logic [15:0] fl, input logic [15:0] ln);
    @(posedge i_clk);
    i_len_valid <= 1'b1;
    i_len_field <= fl;
    i_frame_len <= ln;
    @(posedge i_clk);
    i_len_valid <= 1'b0;
    #1;
    check("len_drop", {15'h0000, exp_drop(ctl_m, fl, ln)}, {15'h0000, o_len_drop});
  endtask : len_chk
  // Cycles until a pulse, bounded so a silent design cannot hang
  task automatic wait_pulse(input logic flush, output int cnt);
    cnt = 0;
    do begin
      @(posedge i_clk);
      #1;
      cnt++;
    end while ((flush ? o_flush_all : o_age_tick) !== 1'b1 && cnt < 1000);
  endtask : wait_pulse
  // ==========================================================
  // Clock and watchdog
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    fail_count++;
    $display("watchdog expired");
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    check("reset levels", 16'h000C, {10'h000, o_switch_en, o_pass_all_frames, o_tx_pause_en,
      o_rx_pause_en, o_aggr_backoff, o_pass_fc_frames});
    rd(swgc_pkg::OFS_IDENT, {ID_V, 1'b0}, "identity reset");
    rd(swgc_pkg::OFS_GCTL1, 16'h3400, "control reset");
    // Identity writes only reach the start bit
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr_next(rnd);
      wr(swgc_pkg::OFS_IDENT, (i == 0) ? 16'hFFFE : rnd);
      rd(swgc_pkg::OFS_IDENT, {ID_V, (i == 0) ? 1'b0 : rnd[0]}, "identity");
      check("switch_en", {15'h0000, (i == 0) ? 1'b0 : rnd[0]}, {15'h0000, o_switch_en});
    end
    // Control one: random values plus all ones and all zeros
    for (int i = 0; i < 14; i++) begin
      rnd = lfsr_next(rnd);
      ctl_m = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : rnd;
      @(posedge i_clk);
      i_sniff_mode <= rnd[5];
      wr(swgc_pkg::OFS_GCTL1, ctl_m);
      @(posedge i_clk);
      #1;
      check("controls", {11'h000, ctl_m[15] & rnd[5], ctl_m[13], ctl_m[12], ctl_m[8], ctl_m[3]},
        {11'h000, o_pass_all_frames, o_tx_pause_en, o_rx_pause_en, o_aggr_backoff,
        o_pass_fc_frames});
      rd(swgc_pkg::OFS_GCTL1, ctl_m, "control one");
      // Length check, corners of the limit among random lengths
      for (int k = 0; k < 2; k++) begin
        rnd = lfsr_next(rnd);
        f = rnd[3] ? CORNER[rnd[2:1]] : {5'h00, rnd[10:0]};
        l = rnd[4] ? f : f + 16'h0001;
        len_chk(f, l);
      end
    end
    // Unmapped places hold nothing; control one reads back right after its write
    wr(8'h04, rnd);
    rd(8'h04, 16'h0000, "unmapped");
    rd(8'h01, 16'h0000, "odd offset");
    ctl_m = rnd ^ 16'h0F0F;
    wr_rd(swgc_pkg::OFS_GCTL1, ctl_m, "write then read");
    rd(swgc_pkg::OFS_GCTL1, ctl_m, "control kept");
    // Normal and fast aging periods, then halted aging
    wr(swgc_pkg::OFS_GCTL1, 16'h3400);
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    check("normal period", 16'(NORM), 16'(n));
    wr(swgc_pkg::OFS_GCTL1, 16'h3600);
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    check("fast period", 16'(FAST), 16'(n));
    wr(swgc_pkg::OFS_GCTL1, 16'h3200);
    wait_pulse(1'b0, n);
    check("aging halted", 16'h03E8, 16'(n));
    // Link drop with link-change aging: flush, one short cycle, then normal
    wr(swgc_pkg::OFS_GCTL1, 16'h3401);
    @(posedge i_clk);
    i_link <= 2'b01;
    wait_pulse(1'b1, n);
    check("flush delay", 16'h0001, {15'h0000, n == 2 || n == 3});
    wait_pulse(1'b0, n2);
    check("link age cycle", 16'h0001, {15'h0000, n2 > LINK - 4 && n2 < LINK + 4});
    wait_pulse(1'b0, n);
    check("back to normal", 16'(NORM), 16'(n));
    // Flush without link-change aging
    wr(swgc_pkg::OFS_GCTL1, 16'h3400);
    @(posedge i_clk);
    i_link <= 2'b11;
    repeat (4) @(posedge i_clk);
    i_link <= 2'b10;
    wait_pulse(1'b1, n);
    check("flush no link age", 16'h0001, {15'h0000, n == 2 || n == 3});
    results();
  end
endmodule : tb_switch_global_control_regs
